// *** dv/lpm_cpu_model.sv ***
// CPU core model that issues wait and stop instructions as one-cycle pulses.
// Assumes its tasks are entered 5 ns after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module lpm_cpu_model (
    // Clock.
    input wire logic clock_i,
    // Instruction strobes and condition code flags.
    output var logic wait_o,
    output var logic stop_o,
    output var logic user_o,
    output var logic sdis_o
);
    initial begin
        {wait_o, stop_o, user_o, sdis_o} = 4'h0;
    end
    // Only strobes and flags leave the core, never peripheral register writes.
    task automatic exec(input logic is_stop, input logic u, input logic s);
        {user_o, sdis_o} = {u, s};
        if (is_stop) stop_o = 1'b1;
        else wait_o = 1'b1;
        @(posedge clock_i);
        #5;
        {wait_o, stop_o} = 2'h0;
    endtask : exec
endmodule : lpm_cpu_model
`default_nettype wire

// *** dv/lpm_ctrl_tb_top.sv ***
// Self-checking bench for the low power mode controller.
// Assumes mode and clock outputs settle on the same edge that takes a request.
`timescale 1ns/100ps
`default_nettype none
module lpm_ctrl_tb_top;
    logic clock = 1'b0, rst_n = 1'b0, nonvolatile_memory = 1'b0, psel = 1'b0, nmi = 1'b0, ext = 1'b0;
    logic irq = 1'b0, tick = 1'b0, wdog = 1'b0, awt = 1'b0, key = 1'b0, async_serial_unit = 1'b0;
    logic dbg = 1'b0, cis = 1'b0, en = 1'b1;
    logic wi, si, uf, sd, ack, tw, wt;
    logic [2:0] mode;
    logic [7:0] clk;
    int num_errors = 0, num_checks = 0;
    initial begin
        forever #25 clock = ~clock;
    end
    lpm_cpu_model cpu (.clock_i(clock), .wait_o(wi), .stop_o(si), .user_o(uf), .sdis_o(sd));
    lpm_ctrl uut (.clock_i(clock), .reset_n_i(rst_n), .wait_instruction_i(wi),
        .stop_instruction_i(si), .ccr_user_flag_i(uf), .ccr_stop_disable_i(sd),
        .nvm_busy_i(nonvolatile_memory), .pseudo_stop_sel_i(psel), .nonmaskable_interrupt_request_i(nmi),
        .external_interrupt_request_i(ext), .unmasked_interrupt_i(irq),
        .periodic_tick_wake_i(tick), .watchdog_wake_i(wdog), .autonomous_wake_timer_wake_i(awt),
        .autonomous_wake_timer_en_i(en), .key_wakeup_pins_i(key), .key_wakeup_en_i(en),
        .async_serial_unit_wake_i(async_serial_unit), .async_serial_unit_wake_en_i(en),
        .debug_port_en_i(dbg), .debug_clock_in_stop_i(cis), .mode_o(mode), .stop_ack_o(ack),
        .cpu_clk_en_o(clk[7]), .sys_clk_en_o(clk[6]), .periph_clk_en_o(clk[5]),
        .osc_en_o(clk[4]), .tick_watchdog_clk_en_o(tw), .wake_timer_clk_en_o(wt),
        .debug_serial_clk_en_o(clk[0]), .regulator_reduced_o(clk[3]),
        .voltage_monitor_en_o(clk[2]), .counter_freeze_o(clk[1]));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #5;
    endtask : cyc
    // Bounded wait, so a stuck mode is reported rather than hanging the run.
    task automatic wait_mode(input logic [2:0] m);
        for (int i = 0; i < 40 && mode !== m; i++) cyc(1);
        chk(mode, m);
    endtask : wait_mode
    task automatic complete_run;
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : complete_run
    initial begin
        #300000;
        num_errors++;
        complete_run();
    end
    initial begin
        cyc(8);
        chk(clk, 8'hf5);
        rst_n = 1'b1;
        for (int k = 0; k < 3; k++) begin
            cpu.exec(1'b0, 1'b0, 1'b0);
            chk(mode, 3'h1);
            chk(clk & 8'hf0, 8'h70);
            {nmi, ext, irq} = 3'(3'h4 >> k);
            cyc(1);
            chk(mode, 3'h0);
            {nmi, ext, irq} = 3'h0;
        end
        // A reset in mid-run also ends wait.
        cpu.exec(1'b0, 1'b0, 1'b0);
        rst_n = 1'b0;
        cyc(1);
        chk(mode, 3'h0);
        rst_n = 1'b1;
        for (int k = 0; k < 3; k++) begin
            nonvolatile_memory = (k == 0);
            cpu.exec(1'b1, k == 1, k == 2);
            chk({ack, mode}, 4'h0);
            nonvolatile_memory = 1'b0;
        end
        for (int k = 0; k < 3; k++) begin
            cpu.exec(1'b1, 1'b0, 1'b0);
            chk(ack, 1'b1);
            chk(mode, 3'h3);
            chk(clk, 8'h0a);
            chk({tw, wt}, 2'h1);
            cyc(2);
            chk({ack, mode}, 4'h3);
            // Disabled wake sources and pseudo-stop-only sources must not end full stop.
            {en, tick, wdog} = 3'h3;
            {key, async_serial_unit, awt} = 3'(3'h4 >> k);
            cyc(4);
            chk(mode, 3'h3);
            {en, tick, wdog} = 3'h4;
            wait_mode(3'h4);
            chk(clk & 8'h1a, 8'h12);
            {key, async_serial_unit, awt} = 3'h0;
            wait_mode(3'h0);
            chk(clk & 8'hf2, 8'hf0);
        end
        psel = 1'b1;
        for (int t = 0; t < 2; t++) begin
            cpu.exec(1'b1, 1'b0, 1'b0);
            chk(mode, 3'h2);
            chk(clk & 8'hf0, 8'h10);
            chk(tw, 1'b1);
            {tick, wdog} = 2'(2'h2 >> t);
            wait_mode(3'h0);
            {tick, wdog} = 2'h0;
        end
        {psel, dbg} = 2'h1;
        for (int c = 1; c >= 0; c--) begin
            cis = c[0];
            cpu.exec(1'b1, 1'b0, 1'b0);
            chk(mode, 3'h3);
            if (c == 1) chk(clk & 8'hfd, 8'hf5);
            else chk(clk & 8'hed, 8'h05);
            chk({tw, wt}, {c[0], 1'b1});
            cyc(2);
            ext = 1'b1;
            wait_mode(3'h0);
            ext = 1'b0;
        end
        complete_run();
    end
endmodule : lpm_ctrl_tb_top
`default_nettype wire

// *** rtl/lpm_ctrl.sv ***
// Low power mode controller: run, wait, pseudo-stop and stop sequencing.
// Assumes CPU request strobes are one-cycle pulses on clock_i; wake pins are asynchronous.
`timescale 1ns/100ps
`default_nettype none
module lpm_ctrl (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic reset_n_i,
    // CPU requests and condition code flags.
    input wire logic wait_instruction_i,
    input wire logic stop_instruction_i,
    input wire logic ccr_user_flag_i,
    input wire logic ccr_stop_disable_i,
    input wire logic nvm_busy_i,
    input wire logic pseudo_stop_sel_i,
    // Interrupt and wake sources.
    input wire logic nonmaskable_interrupt_request_i,
    input wire logic external_interrupt_request_i,
    input wire logic unmasked_interrupt_i,
    input wire logic periodic_tick_wake_i,
    input wire logic watchdog_wake_i,
    input wire logic autonomous_wake_timer_wake_i,
    input wire logic autonomous_wake_timer_en_i,
    input wire logic key_wakeup_pins_i,
    input wire logic key_wakeup_en_i,
    input wire logic async_serial_unit_wake_i,
    input wire logic async_serial_unit_wake_en_i,
    // Debug port.
    input wire logic debug_port_en_i,
    input wire logic debug_clock_in_stop_i,
    // Mode and clock controls.
    output logic [2:0] mode_o,
    output logic stop_ack_o,
    output logic cpu_clk_en_o,
    output logic sys_clk_en_o,
    output logic periph_clk_en_o,
    output logic osc_en_o,
    output logic tick_watchdog_clk_en_o,
    output logic wake_timer_clk_en_o,
    output logic debug_serial_clk_en_o,
    output logic regulator_reduced_o,
    output logic voltage_monitor_en_o,
    output logic counter_freeze_o
);
    lpm_pkg::lpm_mode_e mode_r, mode_nxt;
    logic [lpm_pkg::LPM_CNT_W-1:0] osc_cnt_r, osc_cnt_nxt;
    logic [1:0] key_sync_r, sci_sync_r;

    // Wake pins come from outside the clock domain.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            key_sync_r <= 2'h0;
            sci_sync_r <= 2'h0;
        end else begin
            key_sync_r <= {key_sync_r[0], key_wakeup_pins_i};
            sci_sync_r <= {sci_sync_r[0], async_serial_unit_wake_i};
        end
    end

    wire stop_allowed = !ccr_user_flag_i && !ccr_stop_disable_i;
    wire stop_accept = stop_instruction_i && stop_allowed && !nvm_busy_i;
    wire wait_exit = nonmaskable_interrupt_request_i || external_interrupt_request_i
        || unmasked_interrupt_i;
    wire stop_wake = wait_exit
        || (key_sync_r[1] && key_wakeup_en_i)
        || (sci_sync_r[1] && async_serial_unit_wake_en_i)
        || (autonomous_wake_timer_wake_i && autonomous_wake_timer_en_i);
    wire pstop_wake = stop_wake || periodic_tick_wake_i || watchdog_wake_i;
    wire osc_ready = osc_cnt_r == lpm_pkg::LPM_CNT_W'(lpm_pkg::LPM_OSC_START_CYC - 1);
    wire dbg_all = debug_port_en_i && debug_clock_in_stop_i;
    wire stop_taken = mode_r == lpm_pkg::LPM_RUN && stop_accept;

    always_comb begin
        mode_nxt = mode_r;
        osc_cnt_nxt = lpm_pkg::LPM_CNT_RESET;
        case (mode_r)
            lpm_pkg::LPM_RUN: begin
                if (stop_accept) begin
                    mode_nxt = pseudo_stop_sel_i ? lpm_pkg::LPM_PSTOP : lpm_pkg::LPM_STOP;
                end else if (wait_instruction_i) begin
                    mode_nxt = lpm_pkg::LPM_WAIT;
                end
            end
            lpm_pkg::LPM_WAIT: begin
                if (wait_exit) begin
                    mode_nxt = lpm_pkg::LPM_RUN;
                end
            end
            lpm_pkg::LPM_PSTOP: begin
                if (pstop_wake) begin
                    mode_nxt = lpm_pkg::LPM_RUN;
                end
            end
            lpm_pkg::LPM_STOP: begin
                if (stop_wake) begin
                    mode_nxt = dbg_all ? lpm_pkg::LPM_RUN : lpm_pkg::LPM_WAKE;
                end
            end
            lpm_pkg::LPM_WAKE: begin
                osc_cnt_nxt = osc_cnt_r + 1'b1;
                if (osc_ready) begin
                    mode_nxt = lpm_pkg::LPM_RUN;
                end
            end
            default: mode_nxt = lpm_pkg::LPM_RUN;
        endcase
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_r <= lpm_pkg::LPM_RUN;
            osc_cnt_r <= lpm_pkg::LPM_CNT_RESET;
        end else begin
            mode_r <= mode_nxt;
            osc_cnt_r <= osc_cnt_nxt;
        end
    end

    // Next-state decoded outputs, registered so every output comes from a flop.
    wire n_run = mode_nxt == lpm_pkg::LPM_RUN;
    wire n_wait = mode_nxt == lpm_pkg::LPM_WAIT;
    wire n_pstop = mode_nxt == lpm_pkg::LPM_PSTOP;
    wire n_stop = mode_nxt == lpm_pkg::LPM_STOP;
    wire n_wake = mode_nxt == lpm_pkg::LPM_WAKE;
    wire n_dbg_stop = n_stop && debug_port_en_i;
    wire n_sys = n_run || n_wait || (n_stop && dbg_all);
    wire n_osc = !(n_stop && !dbg_all);
    wire n_reduced = n_stop && !debug_port_en_i;

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_o <= 3'h0;
            stop_ack_o <= 1'b0;
            cpu_clk_en_o <= 1'b1;
            sys_clk_en_o <= 1'b1;
            periph_clk_en_o <= 1'b1;
            osc_en_o <= 1'b1;
            tick_watchdog_clk_en_o <= 1'b1;
            wake_timer_clk_en_o <= 1'b1;
            debug_serial_clk_en_o <= 1'b1;
            regulator_reduced_o <= 1'b0;
            voltage_monitor_en_o <= 1'b1;
            counter_freeze_o <= 1'b0;
        end else begin
            mode_o <= mode_nxt;
            stop_ack_o <= stop_taken;
            cpu_clk_en_o <= n_run || (n_stop && dbg_all);
            sys_clk_en_o <= n_sys;
            periph_clk_en_o <= n_sys;
            osc_en_o <= n_osc;
            tick_watchdog_clk_en_o <= n_sys || n_pstop;
            wake_timer_clk_en_o <= 1'b1;
            debug_serial_clk_en_o <= !n_stop || debug_port_en_i;
            regulator_reduced_o <= n_reduced;
            voltage_monitor_en_o <= !n_stop || n_dbg_stop;
            counter_freeze_o <= (n_stop && !dbg_all) || n_wake;
        end
    end

    wire in_stop = mode_r == lpm_pkg::LPM_STOP;
    sequence stop_entry_s;
        stop_taken;
    endsequence
    // Outputs are looked at one edge after the request, since a wake may follow at once.
    wait_gate_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        mode_r == lpm_pkg::LPM_RUN && !stop_accept && wait_instruction_i |=> !cpu_clk_en_o)
        else $error("cpu clock not gated in wait");
    cpu_halt_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        mode_r == lpm_pkg::LPM_WAIT |-> !cpu_clk_en_o)
        else $error("cpu clock running in wait");
    wait_exit_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        mode_r == lpm_pkg::LPM_WAIT && wait_exit |=> mode_r == lpm_pkg::LPM_RUN)
        else $error("wait not ended by interrupt");
    nvm_block_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        stop_ack_o |-> $past(!nvm_busy_i))
        else $error("stop acked during nvm command");
    ack_pulse_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        stop_ack_o |=> !stop_ack_o)
        else $error("stop ack longer than one cycle");
    stop_noop_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        mode_r == lpm_pkg::LPM_RUN && (ccr_user_flag_i || ccr_stop_disable_i)
        && !wait_instruction_i |=> mode_r == lpm_pkg::LPM_RUN)
        else $error("stop taken despite flags");
    pstop_osc_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        stop_entry_s ##0 pseudo_stop_sel_i |=> osc_en_o && !sys_clk_en_o)
        else $error("pseudo stop clocks wrong");
    pstop_wake_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        mode_r == lpm_pkg::LPM_PSTOP && pstop_wake |=> mode_r == lpm_pkg::LPM_RUN)
        else $error("pseudo stop not ended by wake");
    // A wake in the same cycle legally lifts the stop settings, so it is left out.
    stop_rpm_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        in_stop && !debug_port_en_i && !stop_wake |=> regulator_reduced_o && !osc_en_o)
        else $error("stop without reduced regulator");
    freeze_stop_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        in_stop && !dbg_all && !stop_wake |=> counter_freeze_o)
        else $error("counters not frozen in stop");
    dbg_fpm_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        in_stop && debug_port_en_i |=> !regulator_reduced_o && voltage_monitor_en_o)
        else $error("debug stop regulator wrong");
    dbg_clocks_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        in_stop && $stable(mode_r) && dbg_all |=> sys_clk_en_o && osc_en_o)
        else $error("debug clocks stopped");
    dbg_serial_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        in_stop && debug_port_en_i |=> debug_serial_clk_en_o && wake_timer_clk_en_o)
        else $error("debug serial clock stopped");
    wake_run_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        mode_r == lpm_pkg::LPM_WAKE |-> ##[1:30] mode_r == lpm_pkg::LPM_RUN)
        else $error("wake did not return to run");
endmodule : lpm_ctrl
`default_nettype wire

// *** rtl/lpm_pkg.sv ***
// Constants for the low power mode controller.
// Assumes one 20 MHz system clock and an active-low asynchronous reset.
package lpm_pkg;
    typedef enum logic [2:0] {
        LPM_RUN,
        LPM_WAIT,
        LPM_PSTOP,
        LPM_STOP,
        LPM_WAKE
    } lpm_mode_e;

    // Oscillator restart time after a wake from full stop.
    localparam int LPM_OSC_START_NS = 1000;
    localparam int LPM_CLK_PERIOD_NS = 50;
    localparam int LPM_OSC_START_CYC =
        (LPM_OSC_START_NS + LPM_CLK_PERIOD_NS - 1) / LPM_CLK_PERIOD_NS;
    localparam int LPM_CNT_W = 8;
    localparam logic [LPM_CNT_W-1:0] LPM_CNT_RESET = 8'h00;
endpackage : lpm_pkg
